// >>> smsp_master.sv
// Function
// - Drive mosi with each byte, most significant bit first.
// - Emit exactly eight sck cycles per byte exchanged.
// - Watch own select input for a competing master via mode fault flag.
// - Rate codes 000 to 110 divide clk by 2 through 128.
// - Rate code 111 clocks sck from the external baud generator tick.
// - Full-duplex exchange, master only, shifting out and in together.
// - Mode fault flag raises an error interrupt request.
// - On byte end set done flag and load receive data together.
// - Select low sets mode fault, raises error irq, clears enable, master.
// - Data write during transfer sets collision flag, transfer continues.
// - Phase picks sample and shift edges; polarity sets sck idle level.
module smsp_master
  import smsp_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire smsp_ctl_type  ctl_wdata,
  input  wire logic          ctl_we,
  input  wire logic [7:0]    tx_data,
  input  wire logic          tx_valid,
  output logic               tx_ready,
  input  wire logic          stat_clr,
  input  wire logic          coll_clr,
  input  wire logic          baud_generator_tick,
  output smsp_ctl_type       ctl,
  output smsp_stat_type      stat,
  output logic [7:0]         rx_data,
  output logic               rx_valid,
  input  wire logic          rx_ready,
  output logic               done_irq,
  output logic               fault_irq,
  output logic               sck,
  output logic               mosi,
  input  wire logic          miso,
  input  wire logic          ss_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: change counts once stages two and three agree.
  logic [2:0] ss_sync;
  logic [2:0] miso_sync;
  logic       ss_level;
  logic       miso_level;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ss_sync   <= 3'h7;
      miso_sync <= 3'h0;
    end else begin
      ss_sync   <= {ss_sync[1:0], ss_n};
      miso_sync <= {miso_sync[1:0], miso};
    end
  end

  // Filtered levels hold their value while the last two stages disagree.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ss_level   <= 1'b1;
      miso_level <= 1'b0;
    end else begin
      if (ss_sync[1] == ss_sync[2]) begin
        ss_level <= ss_sync[2];
      end
      if (miso_sync[1] == miso_sync[2]) begin
        miso_level <= miso_sync[2];
      end
    end
  end

  logic ss_fall;
  assign ss_fall = ss_level && (ss_sync[1] == ss_sync[2]) && !ss_sync[2];

  ////////////////////////////////////////////////////////////////////////////
  // Rate selection.
  function automatic logic [SMSP_DIV_W-1:0] smsp_half_div(
    input logic [2:0] code
  );
    // Half period minus one in clk cycles; code 0 gives one cycle per half.
    smsp_half_div = SMSP_DIV_W'((7'h01 << code) - 7'h01);
  endfunction

  logic [2:0]            rate;
  logic [SMSP_DIV_W-1:0] div_cnt;
  logic                  half_tick;
  smsp_state_type        state;
  logic [2:0]            bit_cnt;
  logic [7:0]            shifter;
  logic                  captured;

  assign rate = {ctl.rate_sel_bit2, ctl.rate_sel_bit1, ctl.rate_sel_bit0};

  // Divider counts half periods of sck; the external tick bypasses it.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_cnt <= '0;
    end else if (state == SMSP_IDLE || half_tick) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 7'h01;
    end
  end

  // Each sck half period lasts one tick; external ticks must be sparse.
  assign half_tick = (rate == SMSP_RATE_EXT) ? baud_generator_tick
                   : (div_cnt == smsp_half_div(rate));

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry buffers on the transmit and receive paths.
  logic [7:0] txb [2];
  logic [1:0] txb_cnt;
  logic       txb_rd;
  logic       txb_wr;
  logic [7:0] rxb [2];
  logic [1:0] rxb_cnt;
  logic       rxb_wr;
  logic       rxb_rd;
  logic       start;

  assign tx_ready = (txb_cnt != 2'h2);
  assign txb_wr   = tx_valid && tx_ready;
  assign start    = (state == SMSP_IDLE) && (txb_cnt != 2'h0)
                    && ctl.port_enable && ctl.master_select;
  assign txb_rd   = start;

  // Transmit buffer; entry zero is always the head.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      txb_cnt <= 2'h0;
      txb[0]  <= SMSP_DATA_RESET;
      txb[1]  <= SMSP_DATA_RESET;
    end else begin
      if (txb_rd) begin
        txb[0] <= (txb_wr && txb_cnt == 2'h1) ? tx_data : txb[1];
      end else if (txb_wr && txb_cnt == 2'h0) begin
        txb[0] <= tx_data;
      end
      if (txb_wr && (txb_cnt == (txb_rd ? 2'h2 : 2'h1))) begin
        txb[1] <= tx_data;
      end
      txb_cnt <= 2'(txb_cnt + {1'b0, txb_wr} - {1'b0, txb_rd});
    end
  end

  // A full receive buffer stalls the shifter at the end of a byte.
  // The final bit joins the byte as it is written, so a stall shifts nothing.
  logic [7:0] rx_byte;
  assign rx_byte = {shifter[6:0],
                    ctl.clock_phase ? miso_level : captured};

  assign rxb_rd   = rx_valid && rx_ready;
  assign rx_valid = (rxb_cnt != 2'h0);
  assign rx_data  = rxb[0];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rxb_cnt <= 2'h0;
      rxb[0]  <= SMSP_DATA_RESET;
      rxb[1]  <= SMSP_DATA_RESET;
    end else begin
      if (rxb_rd) begin
        rxb[0] <= (rxb_wr && rxb_cnt == 2'h1) ? rx_byte : rxb[1];
      end else if (rxb_wr && rxb_cnt == 2'h0) begin
        rxb[0] <= rx_byte;
      end
      if (rxb_wr && (rxb_cnt == (rxb_rd ? 2'h2 : 2'h1))) begin
        rxb[1] <= rx_byte;
      end
      rxb_cnt <= 2'(rxb_cnt + {1'b0, rxb_wr} - {1'b0, rxb_rd});
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shift engine: lead edge of each bit, then trail edge.
  logic last_trail;
  assign last_trail = (state == SMSP_TRAIL) && half_tick
                      && (bit_cnt == 3'(SMSP_BYTE_BITS - 1));
  assign rxb_wr     = last_trail && (rxb_cnt != 2'h2);

  always_ff @(posedge clk) begin
    if (!rst_n || stat.mode_fault_flag) begin
      state   <= SMSP_IDLE;
      bit_cnt <= 3'h0;
    end else begin
      unique case (state)
        SMSP_IDLE: begin
          if (start) begin
            state   <= SMSP_LEAD;
            bit_cnt <= 3'h0;
          end
        end
        SMSP_LEAD: begin
          if (half_tick) begin
            state <= SMSP_TRAIL;
          end
        end
        SMSP_TRAIL: begin
          // Hold on the last bit while the receive buffer is full.
          if (last_trail) begin
            if (rxb_cnt != 2'h2) begin
              state <= SMSP_IDLE;
            end
          end else if (half_tick) begin
            state   <= SMSP_LEAD;
            bit_cnt <= bit_cnt + 3'h1;
          end
        end
        default: state <= SMSP_IDLE;
      endcase
    end
  end

  // Phase 0 samples on the lead edge and shifts on the trail edge;
  // phase 1 shifts on the lead edge and samples on the trail edge.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shifter  <= SMSP_DATA_RESET;
      captured <= 1'b0;
    end else if (start) begin
      shifter <= txb[0];
    end else if (half_tick && state == SMSP_LEAD) begin
      if (!ctl.clock_phase) begin
        captured <= miso_level;
      end else if (bit_cnt != 3'h0) begin
        shifter <= {shifter[6:0], captured};
      end
    end else if (half_tick && state == SMSP_TRAIL) begin
      if (ctl.clock_phase) begin
        captured <= miso_level;
      end else if (bit_cnt != 3'(SMSP_BYTE_BITS - 1)) begin
        shifter <= {shifter[6:0], captured};
      end
    end
  end

  // Sck sits at the polarity level when idle and toggles per half period.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sck <= 1'b0;
    end else begin
      sck <= (state == SMSP_LEAD) ? ~ctl.clock_polarity
                                  : ctl.clock_polarity;
    end
  end

  // Mosi comes straight off the shifter, so each bit settles a clock
  // before the sck edge that the slave samples it on.
  assign mosi = shifter[7];

  ////////////////////////////////////////////////////////////////////////////
  // Control word; a mode fault drops enable and master select.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctl <= SMSP_CTL_RESET;
    end else if (ss_fall) begin
      ctl.port_enable   <= 1'b0;
      ctl.master_select <= 1'b0;
    end else if (ctl_we) begin
      ctl      <= ctl_wdata;
      ctl.rsvd <= 1'b0;
    end
  end

  // Status flags; a hardware set wins over a clear in the same cycle.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stat <= '0;
    end else begin
      stat.busy <= (state != SMSP_IDLE) || start;
      if (rxb_wr) begin
        stat.transfer_done_flag <= 1'b1;
      end else if (stat_clr) begin
        stat.transfer_done_flag <= 1'b0;
      end
      if (txb_wr && state != SMSP_IDLE) begin
        stat.write_collision_flag <= 1'b1;
      end else if (coll_clr) begin
        stat.write_collision_flag <= 1'b0;
      end
      if (ss_fall) begin
        stat.mode_fault_flag <= 1'b1;
      end else if (ctl_we) begin
        stat.mode_fault_flag <= 1'b0;
      end
    end
  end

  // Request levels follow the sticky flags.
  assign done_irq  = stat.transfer_done_flag;
  assign fault_irq = stat.mode_fault_flag;

endmodule

// >>> smsp_pkg.sv
package smsp_pkg;

  // Rate selector codes and dividers.
  localparam logic [2:0] SMSP_RATE_EXT   = 3'h7;
  localparam int         SMSP_BYTE_BITS  = 8;
  localparam int         SMSP_DIV_W      = 7;

  // Control field positions in the packed control word.
  localparam int SMSP_CTL_RATE2_POS = 7;
  localparam int SMSP_CTL_EN_POS    = 6;
  localparam int SMSP_CTL_MASTER_SELECT_POS  = 5;
  localparam int SMSP_CTL_CLOCK_POLARITY_POS  = 3;
  localparam int SMSP_CTL_CLOCK_PHASE_POS  = 2;
  localparam int SMSP_CTL_RATE1_POS = 1;
  localparam int SMSP_CTL_RATE0_POS = 0;

  // Reset values.
  localparam logic [7:0] SMSP_CTL_RESET  = 8'h00;
  localparam logic [7:0] SMSP_DATA_RESET = 8'h00;

  // Control fields as written by software.
  typedef struct packed {
    logic       rate_sel_bit2;
    logic       port_enable;
    logic       master_select;
    logic       rsvd;
    logic       clock_polarity;
    logic       clock_phase;
    logic       rate_sel_bit1;
    logic       rate_sel_bit0;
  } smsp_ctl_type;

  // Status flags shown to software.
  typedef struct packed {
    logic transfer_done_flag;
    logic write_collision_flag;
    logic mode_fault_flag;
    logic busy;
  } smsp_stat_type;

  typedef enum logic [1:0] {
    SMSP_IDLE  = 2'b00,
    SMSP_LEAD  = 2'b01,
    SMSP_TRAIL = 2'b11
  } smsp_state_type;

endpackage

// >>> smsp_master_properties.sv
module smsp_master_properties
  import smsp_pkg::*;
(
  input logic          clk,
  input logic          rst_n,
  input smsp_ctl_type  ctl,
  input smsp_stat_type stat,
  input logic          tx_valid,
  input logic          tx_ready,
  input logic          rx_valid,
  input logic          fault_irq,
  input logic          sck,
  input logic          ss_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [2:0] rate;
  logic       sck_q;
  logic [7:0] run;
  logic [4:0] ups;
  ////////////////////////////////////////////////////////////////////////
  // Run counts samples at one sck level; ups counts rises per busy spell.
  assign rate = {ctl.rate_sel_bit2, ctl.rate_sel_bit1, ctl.rate_sel_bit0};
  always_ff @(posedge clk) begin
    sck_q <= sck;
    run   <= (sck != sck_q) ? 8'h01 : run + 8'h01;
    ups   <= stat.busy ? ups + 5'(sck && !sck_q) : 5'h00;
  end
  ////////////////////////////////////////////////////////////////////////
  property p_irq; fault_irq == stat.mode_fault_flag; endproperty
  a_irq: assert property (p_irq) else $error("fault irq wrong");
  property p_done; $rose(stat.transfer_done_flag) |-> rx_valid; endproperty
  a_done: assert property (p_done) else $error("done without data");
  property p_fctl; $rose(stat.mode_fault_flag) |->
    ##[0:1] !(ctl.port_enable || ctl.master_select); endproperty
  a_fctl: assert property (p_fctl) else $error("fault kept enable");
  property p_ss; $fell(ss_n) |-> ##[1:6] stat.mode_fault_flag; endproperty
  a_ss: assert property (p_ss) else $error("select low not flagged");
  property p_coll; tx_valid && tx_ready && stat.busy |=>
    stat.write_collision_flag; endproperty
  a_coll: assert property (p_coll) else $error("collision missed");
  property p_idle; (!stat.busy && $stable(ctl)) [*3] |->
    sck == ctl.clock_polarity; endproperty
  a_idle: assert property (p_idle) else $error("sck idle level wrong");
  property p_dis; !ctl.port_enable [*4] |-> !stat.busy; endproperty
  a_dis: assert property (p_dis) else $error("busy while disabled");
  property p_half; $fell(sck) && !ctl.clock_polarity && rate != SMSP_RATE_EXT
    |-> run == (8'h01 << rate); endproperty
  a_half: assert property (p_half) else $error("half period wrong");
  property p_byte; $fell(stat.busy) && !stat.mode_fault_flag |->
    ups[2:0] == 3'h0 && ups != 5'h00; endproperty
  a_byte: assert property (p_byte) else $error("sck count wrong");
endmodule

// >>> smsp_slave_model.sv
module smsp_slave_model (
  input  wire logic       sck,
  input  wire logic       sel_n,
  input  wire logic       mosi,
  input  wire logic [7:0] reply,
  output logic            miso,
  output logic [7:0]      got
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] shift = 8'h00;
  logic [2:0] bits = 3'h0;
  // Selection preloads the reply so its top bit leads the first edge.
  always @(negedge sel_n) begin
    shift = reply;
    bits = 3'h0;
  end
  // Leading edge captures mosi, top bit first.
  always @(posedge sck) if (!sel_n) begin
    got = {got[6:0], mosi};
    bits = bits + 3'h1;
  end
  // Trailing edge shifts, or reloads after the eighth bit.
  always @(negedge sck) if (!sel_n) begin
    shift = (bits == 3'h0) ? reply : {shift[6:0], 1'b0};
  end
  // Released line shows the inverse, so a stale bit never passes.
  assign miso = sel_n ? ~shift[7] : shift[7];
endmodule

// >>> smsp_master_bench.sv
module smsp_master_bench import smsp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic          clk, rst_n, ctl_we, tx_valid, tx_ready, stat_clr, coll_clr;
  logic          tick, tick_on, rx_valid, rx_ready, done_irq, fault_irq;
  logic          sck, mosi, miso, ss_n, sel_n;
  logic [7:0]    tx_data, rx_data, reply, got;
  smsp_ctl_type  ctl_wdata, ctl;
  smsp_stat_type stat;
  int            failures, compares, hi_cnt, rise_cnt, tk;
  smsp_master smsp_master_inst (.clk, .rst_n, .ctl_wdata, .ctl_we, .tx_data,
    .tx_valid, .tx_ready, .stat_clr, .coll_clr, .baud_generator_tick(tick),
    .ctl, .stat, .rx_data, .rx_valid, .rx_ready, .done_irq, .fault_irq, .sck,
    .mosi, .miso, .ss_n);
  smsp_slave_model smsp_slave_model_inst (.sck, .sel_n, .mosi, .reply, .miso,
    .got);
  ////////////////////////////////////////////////////////////////////////
  // Clock, a slow external tick so miso survives the synchroniser, tallies.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(negedge clk) begin
    tk <= (tk + 1) % 6;
    tick <= tick_on && tk == 0;
  end
  always @(posedge clk) hi_cnt <= hi_cnt + int'(sck);
  always @(posedge sck) rise_cnt <= rise_cnt + 1;
  ////////////////////////////////////////////////////////////////////////
  task automatic check(string what, logic [15:0] exp, logic [15:0] seen);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    if (failures == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic setc(logic [7:0] w);
    ctl_wdata = w;
    ctl_we = 1'b1;
    @(negedge clk);
    ctl_we = 1'b0;
    @(negedge clk);
  endtask
  task automatic send(logic [7:0] b, bit last);
    tx_data = b;
    tx_valid = 1'b1;
    @(negedge clk);
    if (last) tx_valid = 1'b0;
  endtask
  // Waits for a word under a bound, then pops it.
  task automatic get_rx(logic [7:0] exp, bit chk);
    int n;
    n = 0;
    while (rx_valid !== 1'b1) begin
      n++;
      if (n > 4000) begin
        failures++;
        stop_test();
      end
      @(negedge clk);
    end
    if (chk) check("rx_data", exp, rx_data);
    rx_ready = 1'b1;
    @(negedge clk);
    rx_ready = 1'b0;
    @(negedge clk);
  endtask
  // Below rate code 3 the half period is shorter than the miso synchroniser.
  task automatic xfer(logic [2:0] c, logic [7:0] b);
    int h, e;
    setc({c[2], 2'b11, 3'h0, c[1:0]});
    h = hi_cnt;
    e = rise_cnt;
    send(b, 1'b1);
    get_rx(reply, c > 3'h2);
    check("sent", b, got);
    check("edges", 16'h0008, 16'(rise_cnt - e));
    if (c != SMSP_RATE_EXT) check("high", 16'(8 << c), 16'(hi_cnt - h));
    check("done", 16'h0001, 16'(done_irq && stat.transfer_done_flag));
    stat_clr = 1'b1;
    @(negedge clk);
    stat_clr = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {ctl_we, tx_valid, stat_clr, coll_clr, rx_ready, tick_on, tick} = '0;
    {failures, compares, hi_cnt, rise_cnt, tk} = '0;
    ctl_wdata = '0;
    tx_data = 8'h00;
    reply = 8'h3c;
    ss_n = 1'b1;
    sel_n = 1'b1;
    rst_n = 1'b0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    sel_n = 1'b0;
    check("reset", 16'h0002, 16'({ctl, stat, tx_ready, sck}));
    for (int c = 0; c < 8; c++) begin
      tick_on = (c == 7);
      xfer(3'(c), 8'ha5 ^ 8'(c));
    end
    tick_on = 1'b0;
    setc(8'h03);
    send(8'h11, 1'b0);
    send(8'h22, 1'b1);
    check("full", 16'h0000, 16'(tx_ready));
    setc(8'h63);
    repeat (2) @(negedge clk);
    send(8'h33, 1'b1);
    check("coll", 16'h0001, 16'(stat.write_collision_flag));
    repeat (700) @(negedge clk);
    check("stall", 16'h0001, 16'(stat.busy && rx_valid));
    repeat (3) get_rx(reply, 1'b1);
    check("last", 16'h0033, 16'(got));
    coll_clr = 1'b1;
    @(negedge clk);
    coll_clr = 1'b0;
    check("coll_clr", 16'h0000, 16'(stat.write_collision_flag));
    ss_n = 1'b0;
    repeat (8) @(negedge clk);
    check("fault", 16'h000c, 16'({stat.mode_fault_flag, fault_irq,
      ctl.port_enable, ctl.master_select}));
    ss_n = 1'b1;
    repeat (4) @(negedge clk);
    setc(8'h63);
    check("refault", 16'h0003, 16'({stat.mode_fault_flag, fault_irq,
      ctl.port_enable, ctl.master_select}));
    sel_n = 1'b1;
    setc(8'h08);
    check("idle", 16'h0001, 16'(sck));
    stop_test();
  end
endmodule
bind smsp_master smsp_master_properties smsp_master_properties_inst (.clk,
  .rst_n, .ctl, .stat, .tx_valid, .tx_ready, .rx_valid, .fault_irq, .sck,
  .ss_n);
